/* verilog/pcg_pkg.sv */
// constants and types for the peripheral clock gate bank
`default_nettype none

package pcg_pkg;

	////////////////////////////////////////////////////////////////////////
	// register map (byte addresses, low 16 bits of haddr)
	localparam int unsigned NUM_REGS = 6;  // gate registers in the bank
	localparam logic [5:0][15:0] GATE_OFFSET = {
		16'hf290,  // misc_peripheral_gate
		16'hf280,  // serial_link_gate
		16'hf270,  // timer_gate
		16'hf260,  // capture_compare_gate
		16'hf250,  // comparator_gate
		16'hf240   // analog_unit_gate
	};
	localparam logic [15:0] CFG_OFFSET = 16'hf000;  // config_control_reg
	localparam int unsigned LOCK_BIT   = 12;        // gate_write_lock

	////////////////////////////////////////////////////////////////////////
	// implemented gate bits per register, index 0 = analog_unit_gate
	localparam logic [5:0][31:0] GATE_IMPL = {
		32'h0001_0003,  // parallel port, ref clock out, rtc
		32'h0103_0303,  // usb, i2c b/a, spi b/a, uart b/a
		32'h0000_001f,  // timer5..timer1
		32'h001f_001f,  // compare5..1, capture5..1
		32'h0000_0007,  // comparator3..1
		32'h0000_1101   // cmp vref, charge time, adc
	};
	localparam logic [31:0] GATE_RESET = 32'h0000_0000;  // all ungated
	localparam logic [31:0] CFG_RESET  = 32'h0000_0000;  // lock open

	////////////////////////////////////////////////////////////////////////
	// bus decode
	localparam logic [2:0] IDX_CFG  = 3'h6;  // decode: config register
	localparam logic [2:0] IDX_NONE = 3'h7;  // decode: unmapped
	localparam logic [2:0] SIZE_WORD = 3'h2; // only word transfers taken

	// alias operation, selected by haddr[3:2]
	typedef enum logic [1:0] {
		OP_WRITE,
		OP_CLR,
		OP_SET,
		OP_INV
	} pcg_op_e;

	// captured address phase
	typedef struct packed {
		logic      valid;  // transfer in data phase
		logic      write;  // write when set
		logic [2:0] idx;   // decoded register
		pcg_op_e   op;     // alias operation
	} pcg_xfer_s;

	typedef logic [5:0][31:0] pcg_bank_t;  // one bit per peripheral

endpackage

`default_nettype wire

/* verilog/pcg_bank.sv */
// peripheral clock gate bank with ahb-lite register slave
`default_nettype none

module pcg_bank #(
	// implemented bits, narrowed on smaller variants
	parameter pcg_pkg::pcg_bank_t IMPL_MASK = pcg_pkg::GATE_IMPL
) (
	input  wire logic          hclk,         // bus clock
	input  wire logic          hresetn,      // async reset, low
	input  wire logic          hsel,         // slave select
	input  wire logic [31:0]   haddr,        // byte address
	input  wire logic [1:0]    htrans,       // transfer type
	input  wire logic          hwrite,       // write when high
	input  wire logic [2:0]    hsize,        // transfer size
	input  wire logic [31:0]   hwdata,       // write data
	input  wire logic          hready,       // bus ready in
	output logic [31:0]        hrdata,       // read data
	output logic               hreadyout,    // slave ready
	output logic               hresp,        // always okay
	input  wire logic          key_unlocked, // unlock sequence done
	input  wire logic          gate_lock_one_shot, // boot word 3 bit 28
	output pcg_pkg::pcg_bank_t gate_state,   // gate bits, 1 = off
	output pcg_pkg::pcg_bank_t periph_reg_en, // peripheral regs live
	output pcg_pkg::pcg_bank_t periph_clk    // gated clocks
);

	////////////////////////////////////////////////////////////////////////
	// declarations
	pcg_pkg::pcg_bank_t  gate;       // gate registers
	pcg_pkg::pcg_xfer_s  xfer;       // captured address phase
	pcg_pkg::pcg_xfer_s  next_xfer;  // address phase being offered
	logic                gate_write_lock; // lock bit
	logic                lock_held;  // lock pinned until reset
	logic                rd_pend;    // read wait state
	logic                addr_take;  // address phase accepted
	logic                wr_fire;    // write data phase now
	logic                gate_wr;    // write hits a gate register
	logic                cfg_wr;     // write hits config register

	////////////////////////////////////////////////////////////////////////
	// decode a byte address to a register index
	function automatic logic [2:0] reg_index(input logic [31:0] a);
		logic [2:0] idx;
		idx = pcg_pkg::IDX_NONE;
		for (int i = 0; i < pcg_pkg::NUM_REGS; i++)
		begin
			if ({a[15:4], 4'h0} == pcg_pkg::GATE_OFFSET[i])
			begin
				idx = 3'(i);
			end
		end
		// config register has no aliases
		if (a[15:0] == pcg_pkg::CFG_OFFSET)
		begin
			idx = pcg_pkg::IDX_CFG;
		end
		return idx;
	endfunction

	// read value of a register, base or alias address alike
	function automatic logic [31:0] read_value(input logic [2:0] idx);
		logic [31:0] v;
		v = 32'h0000_0000;
		if (idx == pcg_pkg::IDX_CFG)
		begin
			v[pcg_pkg::LOCK_BIT] = gate_write_lock;
		end
		else if (idx < pcg_pkg::IDX_CFG)
		begin
			v = gate[idx];
		end
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// address phase
	// only word transfers are taken; others pass with no effect
	assign addr_take = hsel & hready & htrans[1]
	                 & (hsize == pcg_pkg::SIZE_WORD);

	always_comb
	begin
		next_xfer.valid = addr_take;
		next_xfer.write = hwrite;
		next_xfer.idx   = reg_index(haddr);
		next_xfer.op    = pcg_pkg::pcg_op_e'(haddr[3:2]);
	end

	// hold the address phase for the data phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			xfer <= '0;
		end
		else if (hready)
		begin
			xfer <= next_xfer;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// data phase handshake
	// reads add one wait state so hrdata comes from a flop and
	// never races a write retiring at the same edge
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			rd_pend <= 1'b0;
		end
		else
		begin
			rd_pend <= addr_take & ~hwrite;
		end
	end

	assign hreadyout = ~rd_pend;
	assign hresp     = 1'b0;

	// read data captured at the end of the wait state
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata <= 32'h0000_0000;
		end
		else if (rd_pend)
		begin
			// unmapped addresses read as zero
			hrdata <= read_value(xfer.idx);
		end
	end

	assign wr_fire = xfer.valid & xfer.write & hready;
	assign gate_wr = wr_fire & (xfer.idx < pcg_pkg::IDX_CFG);
	assign cfg_wr  = wr_fire & (xfer.idx == pcg_pkg::IDX_CFG);

	////////////////////////////////////////////////////////////////////////
	// gate registers
	// a locked write is acknowledged like any other, it just
	// leaves the bank untouched
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			for (int r = 0; r < pcg_pkg::NUM_REGS; r++)
			begin
				gate[r] <= pcg_pkg::GATE_RESET;
			end
		end
		else if (gate_wr && !gate_write_lock)
		begin
			// masking keeps absent bits at zero
			case (xfer.op)
				pcg_pkg::OP_WRITE:
					gate[xfer.idx] <= hwdata & IMPL_MASK[xfer.idx];
				pcg_pkg::OP_CLR:
					gate[xfer.idx] <= gate[xfer.idx] & ~hwdata;
				pcg_pkg::OP_SET:
					gate[xfer.idx] <= gate[xfer.idx]
					                | (hwdata & IMPL_MASK[xfer.idx]);
				pcg_pkg::OP_INV:
					gate[xfer.idx] <= gate[xfer.idx]
					                ^ (hwdata & IMPL_MASK[xfer.idx]);
				default:
					gate[xfer.idx] <= gate[xfer.idx];
			endcase
		end
	end

	// bit positions per peripheral live in the implemented mask
	assign gate_state = gate;

	////////////////////////////////////////////////////////////////////////
	// write lock
	// the lock only moves after the unlock sequence; once pinned
	// by the one-shot option a clearing write is ignored
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			gate_write_lock <= pcg_pkg::CFG_RESET[pcg_pkg::LOCK_BIT];
		end
		else if (cfg_wr && key_unlocked)
		begin
			if (hwdata[pcg_pkg::LOCK_BIT])
			begin
				gate_write_lock <= 1'b1;
			end
			// the one-shot input is looked at directly as well, so a
			// clear in the cycle right after the set cannot slip past
			else if (!lock_held && !gate_lock_one_shot)
			begin
				gate_write_lock <= 1'b0;
			end
		end
	end

	// pinned state survives everything but reset
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lock_held <= 1'b0;
		end
		else if (gate_write_lock && gate_lock_one_shot)
		begin
			lock_held <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// peripheral register access enables
	// a gated peripheral must drop bus writes and its read data is
	// not to be trusted; one cycle behind the gate bit
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			periph_reg_en <= '0;
		end
		else
		begin
			periph_reg_en <= ~gate & IMPL_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// glitch-free clock gates
	// enable changes on the falling edge while hclk is low, so the
	// and gate never cuts a high phase short; the peripheral is
	// expected to be switched off before its clock stops
	for (genvar r = 0; r < 6; r++)
	begin : g_reg
		for (genvar b = 0; b < 32; b++)
		begin : g_bit
			if (IMPL_MASK[r][b])
			begin : g_on
				logic run;  // clock enable, stable through the high phase
				always_ff @(negedge hclk or negedge hresetn)
				begin
					if (!hresetn)
					begin
						// limitation: reset reopens the clock at once,
						// acceptable since the peripheral is in reset too
						run <= 1'b1;
					end
					else
					begin
						run <= ~gate[r][b];
					end
				end
				assign periph_clk[r][b] = hclk & run;
			end
			else
			begin : g_off
				// absent peripheral: no clock at all
				assign periph_clk[r][b] = 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// locked writes leave the bank untouched
	lock_blocks_write_a: assert property (
		gate_wr && gate_write_lock |=> gate == $past(gate)
	) else $error("gate bank changed while locked");

	// set alias ors in the written ones
	alias_set_a: assert property (
		gate_wr && !gate_write_lock && xfer.op == pcg_pkg::OP_SET
		|=> gate[$past(xfer.idx)] == ($past(gate[xfer.idx])
		    | ($past(hwdata) & IMPL_MASK[$past(xfer.idx)]))
	) else $error("set alias wrong");

	// clear alias removes the written ones
	alias_clr_a: assert property (
		gate_wr && !gate_write_lock && xfer.op == pcg_pkg::OP_CLR
		|=> gate[$past(xfer.idx)]
		    == ($past(gate[xfer.idx]) & ~$past(hwdata))
	) else $error("clear alias wrong");

	// invert alias toggles the written ones
	alias_inv_a: assert property (
		gate_wr && !gate_write_lock && xfer.op == pcg_pkg::OP_INV
		|=> gate[$past(xfer.idx)] == ($past(gate[xfer.idx])
		    ^ ($past(hwdata) & IMPL_MASK[$past(xfer.idx)]))
	) else $error("invert alias wrong");

	// plain write stores the implemented ones
	alias_write_a: assert property (
		gate_wr && !gate_write_lock && xfer.op == pcg_pkg::OP_WRITE
		|=> gate[$past(xfer.idx)]
		    == ($past(hwdata) & IMPL_MASK[$past(xfer.idx)])
	) else $error("plain gate write wrong");

	// absent bits never hold a one
	unimpl_zero_a: assert property (
		(gate & ~IMPL_MASK) == '0
	) else $error("unimplemented gate bit set");

	// pinned lock stays set
	one_shot_hold_a: assert property (
		lock_held |-> gate_write_lock ##1 gate_write_lock
	) else $error("pinned lock cleared");

	// one-shot pins the lock within a cycle
	one_shot_pin_a: assert property (
		gate_write_lock && gate_lock_one_shot |=> lock_held
	) else $error("one-shot did not pin lock");

	// with the one-shot option a set lock never drops
	one_shot_keep_a: assert property (
		gate_write_lock && gate_lock_one_shot |=> gate_write_lock
	) else $error("lock cleared under one-shot");

	// lock cannot move without the key
	key_needed_a: assert property (
		!key_unlocked |=> $stable(gate_write_lock) || lock_held
	) else $error("lock moved without unlock");

	// register access follows the gate a cycle later; the enables
	// lag a reset release by one cycle, so start out of reset only
	access_en_a: assert property (
		hresetn |=> periph_reg_en == (~$past(gate) & IMPL_MASK)
	) else $error("access enable mismatch");

	// a write is answered at once, locked or not
	write_ready_a: assert property (
		addr_take && hwrite |=> hreadyout
	) else $error("write wait state seen");

	// a read waits exactly one cycle
	read_wait_a: assert property (
		addr_take && !hwrite |=> !hreadyout ##1 hreadyout
	) else $error("read wait state wrong");

	lock_write_c: cover property (gate_wr && gate_write_lock);
	inv_write_c:  cover property (
		gate_wr && !gate_write_lock && xfer.op == pcg_pkg::OP_INV);
	pinned_c:     cover property (cfg_wr && key_unlocked && lock_held);
	read_c:       cover property (rd_pend ##1 hreadyout);
	pin_c:        cover property (
		gate_write_lock && gate_lock_one_shot && !lock_held);

endmodule

`default_nettype wire

/* sim/pcg_periph_model.sv */
// behavioural model of one gated peripheral behind the gate bank
`default_nettype none

module pcg_periph_model (
	input  wire logic        pclk,   // gated peripheral clock
	input  wire logic        reg_en, // peripheral registers live
	input  wire logic        on,     // peripheral switched on
	output logic [15:0]      ticks,  // clock edges seen
	output logic             misuse  // gated while still on
);
	timeunit 1ns;
	timeprecision 1ps;

	initial ticks = 16'h0000;
	initial misuse = 1'b0;

	// only real edges advance the count, so a cut clock freezes it
	always @(posedge pclk)
		ticks <= ticks + 16'h0001;

	// gating a running peripheral leaves it undefined: flag it
	always @(negedge reg_en)
		if (on)
			misuse <= 1'b1;
endmodule

`default_nettype wire

/* sim/peripheral_clock_gate_bank_tb.sv */
// self-checking bench for the peripheral clock gate bank
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
	n_mismatch++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module peripheral_clock_gate_bank_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic               hclk = 1'b0;  // bus clock
	logic               hresetn;      // async reset, low
	logic               hsel;         // slave select
	logic               hwrite;       // write when high
	logic               key_unlocked; // unlock sequence done
	logic               one_shot;     // one-shot lock config
	logic [31:0]        haddr;        // byte address
	logic [31:0]        hwdata;       // write data
	logic [31:0]        hrdata;       // read data
	logic [31:0]        rd;           // last data phase capture
	logic [1:0]         htrans;       // transfer type
	logic [2:0]         hsize;        // transfer size
	logic               hreadyout;    // slave ready, also hready
	logic               hresp;        // response
	logic               on;           // adc switched on
	logic               misuse;       // model saw gating while on
	logic               locked;       // bench view of the lock
	logic               bad_size;     // next transfer not a word
	logic [15:0]        ticks;        // adc clock edges
	logic [15:0]        t0;           // snapshot of ticks
	pcg_pkg::pcg_bank_t gate_state;   // gate outputs
	pcg_pkg::pcg_bank_t reg_en;       // register enables
	pcg_pkg::pcg_bank_t pclk;         // gated clocks
	pcg_pkg::pcg_bank_t expv;         // expected gate registers
	int                 n_mismatch;   // mismatches
	int                 num_checks;   // comparisons
	int                 seed;         // random seed

	always #2 hclk = ~hclk;

	pcg_bank u_pcg_bank (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp),
		.key_unlocked(key_unlocked), .gate_lock_one_shot(one_shot),
		.gate_state(gate_state), .periph_reg_en(reg_en),
		.periph_clk(pclk)
	);

	pcg_periph_model u_pcg_periph_model (
		.pclk(pclk[0][0]), .reg_en(reg_en[0][0]), .on(on),
		.ticks(ticks), .misuse(misuse)
	);

	////////////////////////////////////////////////////////////////////////
	// verdict and end of run
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// wait for hready sampled high; settled value read mid-cycle
	task automatic wait_rdy();
		int i;
		i = 0;
		@(negedge hclk);
		while (hreadyout !== 1'b1 && i < 20)
		begin
			@(negedge hclk);
			i++;
		end
		if (hreadyout !== 1'b1)
		begin
			n_mismatch++;
			close_out();
		end
		else
		begin
			rd = hrdata;
			@(posedge hclk);
		end
	endtask

	// one single transfer, word-sized unless bad_size: address phase, then data phase
	task automatic xfer(input logic w, input logic [31:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= bad_size ? 3'h0 : pcg_pkg::SIZE_WORD;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
	endtask

	// expected effect of a write through base or alias address
	function automatic logic [31:0] upd(logic [1:0] op, logic [31:0] o,
		logic [31:0] d);
		case (op)
			2'h0: return d;
			2'h1: return o & ~d;
			2'h2: return o | d;
			default: return o ^ d;
		endcase
	endfunction

	task automatic gw(input int r, input logic [1:0] op,
		input logic [31:0] d);
		xfer(1'b1, {16'h0000, pcg_pkg::GATE_OFFSET[r] +
			{12'h000, op, 2'b00}}, d);
		if (!locked)
			expv[r] = upd(op, expv[r], d) & pcg_pkg::GATE_IMPL[r];
	endtask

	// read back every gate register and compare gate_state, reg_en and hresp
	task automatic chk_all();
		for (int r = 0; r < 6; r++)
		begin
			xfer(1'b0, {16'h0000, pcg_pkg::GATE_OFFSET[r]}, 32'h0);
			`CHK("gate reg", expv[r], rd)
		end
		`CHK("gate out", expv, gate_state)
		`CHK("reg en", ~expv & pcg_pkg::GATE_IMPL, reg_en)
		`CHK("okay", 1'b0, hresp)
	endtask

	task automatic cfg(input logic [31:0] d, input logic [31:0] e);
		xfer(1'b1, {16'h0000, pcg_pkg::CFG_OFFSET}, d);
		xfer(1'b0, {16'h0000, pcg_pkg::CFG_OFFSET}, 32'h0);
		`CHK("lock", e, rd)
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		seed = 32'h7d2ed9a8;
		{hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
		{hresetn, key_unlocked, one_shot, on, locked, bad_size} = '0;
		expv = '0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk_all();
		key_unlocked <= 1'b1;
		for (int r = 0; r < 6; r++)
			gw(r, 2'h0, 32'hffff_ffff);
		chk_all();
		repeat (3)
			for (int k = 0; k < 24; k++)
				gw(k % 6, 2'(k / 6), $random(seed));
		chk_all();
		// peripheral stopped first, then gated, then restarted
		gw(0, 2'h1, 32'h1);
		on <= 1'b1;
		repeat (5) @(posedge hclk);
		on <= 1'b0;
		gw(0, 2'h2, 32'h1);
		repeat (4) @(posedge hclk);
		t0 = ticks;
		repeat (10) @(posedge hclk);
		`CHK("frozen clk", t0, ticks)
		gw(0, 2'h1, 32'h1);
		repeat (10) @(posedge hclk);
		`CHK("clk back", 1'b1, ticks > t0 + 16'h0007)
		`CHK("misuse", 1'b0, misuse)
		// lock handling
		key_unlocked <= 1'b0;
		cfg(32'h0000_1000, 32'h0);
		key_unlocked <= 1'b1;
		cfg(32'h0000_1000, 32'h0000_1000);
		locked = 1'b1;
		gw(1, 2'h0, 32'h5);
		chk_all();
		cfg(32'h0, 32'h0);
		locked = 1'b0;
		one_shot <= 1'b1;
		cfg(32'h0000_1000, 32'h0000_1000);
		locked = 1'b1;
		cfg(32'h0, 32'h0000_1000);
		gw(3, 2'h3, 32'hffff_ffff);
		chk_all();
		hresetn <= 1'b0;
		one_shot <= 1'b0;
		@(posedge hclk);
		hresetn <= 1'b1;
		expv = '0;
		locked = 1'b0;
		@(posedge hclk);
		cfg(32'h0, 32'h0);
		gw(2, 2'h2, 32'h0000_0003);
		xfer(1'b1, 32'h0000_f100, 32'hffff_ffff);
		// a byte-sized write must be ignored
		bad_size = 1'b1;
		xfer(1'b1, {16'h0000, pcg_pkg::GATE_OFFSET[4]},
			32'hffff_ffff);
		bad_size = 1'b0;
		// alias addresses read back the register itself
		xfer(1'b0, {16'h0000, pcg_pkg::GATE_OFFSET[2] + 16'h0008},
			32'h0);
		`CHK("alias rd", expv[2], rd)
		chk_all();
		close_out();
	end

	initial
	begin
		repeat (50000) @(posedge hclk);
		n_mismatch++;
		close_out();
	end
endmodule

`default_nettype wire
